// >>> bench/adpt_display_model.sv
`timescale 1ns/10ps

module adpt_display_model (
  input  wire logic                        sys_clk,
  input  wire logic [1:0]                  cs_pin,
  input  wire logic [1:0]                  rd_pin,
  input  wire logic [1:0]                  wr_pin,
  input  wire logic [3:0]                  pol,
  input  wire logic                        mode_68k,
  input  wire logic [adpt_pkg::DATA_W-1:0] resp_word,
  output logic [adpt_pkg::DATA_W-1:0]      data_i
);
  import adpt_pkg::*;

  logic cs_on;
  logic rd_on;
  logic en_on;

  // either half of a cycle counts as active
  assign cs_on = (cs_pin[0] == pol[0]) || (cs_pin[1] == pol[0]);
  assign rd_on = (rd_pin[0] == pol[1]) || (rd_pin[1] == pol[1]);
  assign en_on = !mode_68k || (wr_pin[0] == pol[2]) || (wr_pin[1] == pol[2]);

  initial data_i = 16'h0000;

  // answer only under the read strobe, otherwise the released bus toggles
  always @(posedge sys_clk) begin
    if (cs_on && rd_on && en_on) begin
      data_i <= resp_word;
    end else begin
      data_i <= ~data_i;
    end
  end
endmodule : adpt_display_model

// >>> bench/adpt_top_test.sv
`timescale 1ns/10ps

module adpt_top_test;
  import adpt_pkg::*;

  logic              sys_clk, reset, req_valid, req_ready, rdata_valid;
  adpt_req_s         req_data;
  adpt_req_s         txq[$];
  logic [DATA_W-1:0] rdata, dout, din, resp;
  logic [9:0]        clkp, per, up, dn, smp;
  logic [3:0]        pol;
  logic              m68k, type2, single, busy, oe_n, rs;
  logic [4:0]        pause;
  logic [1:0]        rwait, cs, rd, wr, dsel;
  logic [1:0]        cs_c[64], rd_c[64], wr_c[64], ds_c[64];
  logic              oe_c[64], rv_c[64], rs_c[64];
  logic [DATA_W-1:0] do_c[64], rx_c[64];
  int                bad_count = 0;
  int                checks = 0;
  int                cyc = 0;

  initial begin
    sys_clk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  adpt_top u_adpt_top (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req_data(req_data), .rdata_valid(rdata_valid), .rdata(rdata), .read_period_setting(per),
    .write_period_setting(per), .fast_clock_period_setting(clkp), .read_assert_setting(up),
    .read_release_setting(dn), .write_assert_setting(up), .write_release_setting(dn),
    .read_sample_setting(smp), .display_signal_polarity_reg(pol), .mode_68k(m68k), .type2_sel(type2),
    .single_access(single), .pause_cycles(pause), .read_wait_states(rwait), .busy(busy), .cs_pin(cs),
    .rd_pin(rd), .wr_pin(wr), .rs_pin(rs), .disp_sel(dsel), .data_o(dout), .data_oe_n(oe_n), .data_i(din));

  adpt_display_model u_adpt_display_model (.sys_clk(sys_clk), .cs_pin(cs), .rd_pin(rd), .wr_pin(wr),
    .pol(pol), .mode_68k(m68k), .resp_word(resp), .data_i(din));

  function automatic int cdiv(int a, int b);
    return (a + b - 1) / b;
  endfunction : cdiv

  // expected pin pair for cycle c of an access, active in half slots u..d-1
  function automatic logic [1:0] ep(int c, int u, int d, logic p);
    ep[0] = (2 * c >= u && 2 * c < d) ? p : ~p;
    ep[1] = (2 * c + 1 >= u && 2 * c + 1 < d) ? p : ~p;
  endfunction : ep

  function automatic adpt_req_s mk(logic r, logic [1:0] ds, logic l, logic [15:0] d);
    return '{r, l, ds, l, d};
  endfunction : mk

  task automatic cmp_pin(logic [1:0] got, logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic cmp_word(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic setup(logic t2, logic m6, logic [3:0] pl, logic sg, logic [4:0] ps, logic [9:0] p,
                       logic [9:0] pr, logic [9:0] u, logic [9:0] d, logic [9:0] s, logic [1:0] w);
    int n;
    n = 0;
    do begin @(negedge sys_clk); n++; end while (busy !== 1'h0 && n < 200);
    cmp_pin({1'h0, n < 200}, 2'h1);
    @(posedge sys_clk);
    type2 <= t2;
    m68k <= m6;
    pol <= pl;
    single <= sg;
    pause <= ps;
    clkp <= p;
    per <= pr;
    up <= u;
    dn <= d;
    smp <= s;
    rwait <= w;
  endtask : setup

  task automatic send();
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'h1;
    foreach (txq[i]) begin
      req_data <= txq[i];
      do begin @(negedge sys_clk); n++; end while (req_ready !== 1'h1 && n < 50);
      @(posedge sys_clk);
    end
    cmp_pin({1'h0, n < 50}, 2'h1);
    req_valid <= 1'h0;
  endtask : send

  // waits for the first active control, then records 64 cycles
  task automatic capture();
    int n;
    n = 0;
    do begin @(negedge sys_clk); n++; end
    while (cs === ~{2{pol[0]}} && rd === ~{2{pol[1]}} && wr === ~{2{pol[2]}} && n < 60);
    cmp_pin({1'h0, n < 60}, 2'h1);
    for (int i = 0; i < 64; i++) begin
      cs_c[i] = cs;
      rd_c[i] = rd;
      wr_c[i] = wr;
      oe_c[i] = oe_n;
      do_c[i] = dout;
      rv_c[i] = rdata_valid;
      rx_c[i] = rdata;
      rs_c[i] = rs;
      ds_c[i] = dsel;
      @(negedge sys_clk);
    end
  endtask : capture

  task automatic reset_test();
    @(negedge sys_clk);
    cmp_pin(cs, 2'h3);
    cmp_pin(rd, 2'h3);
    cmp_pin(wr, 2'h3);
    cmp_pin({oe_n, req_ready}, 2'h3);
    $display("test reset done");
  endtask : reset_test

  // two-word burst, clamped pause, then a one-word burst
  task automatic write_burst_test();
    int ln, u, d, c, b;
    logic a;
    ln = cdiv(35, 10);
    u = cdiv(10, 10);
    d = cdiv(50, 10);
    b = 2 * ln + int'(PAUSE_MIN);
    setup(1'h1, 1'h0, 4'h0, 1'h0, 5'h02, 10'h00A, 10'h023, 10'h005, 10'h019, 10'h000, 2'h0);
    txq = {mk(1'h0, 2'h0, 1'h0, 16'h1234), mk(1'h0, 2'h0, 1'h0, 16'hBEEF), mk(1'h0, 2'h1, 1'h1, 16'h5AA5)};
    fork send(); capture(); join
    for (int i = 0; i < b + ln; i++) begin
      a = (i < 2 * ln) || (i >= b);
      c = (i < b) ? i % ln : i - b;
      cmp_pin(cs_c[i], a ? ep(c, 0, 2 * ln, 1'h0) : 2'h3);
      cmp_pin(wr_c[i], a ? ep(c, u, d, 1'h0) : 2'h3);
      cmp_pin(rd_c[i], 2'h3);
      cmp_pin({1'h0, rs_c[i]}, {1'h0, i < b});
      cmp_pin(ds_c[i], {1'h0, i >= b});
      cmp_pin({1'h0, oe_c[i]}, {1'h0, ~a});
      if (a) cmp_word(do_c[i], i < ln ? 16'h1234 : (i < b ? 16'hBEEF : 16'h5AA5));
    end
    $display("test write_burst done");
  endtask : write_burst_test

  // type 1 with inverted polarity, single access gaps
  task automatic single_pol_test();
    int ln, u, d, c;
    logic a;
    ln = cdiv(10, 4);
    u = cdiv(6, 4);
    d = cdiv(14, 4);
    setup(1'h0, 1'h0, 4'hF, 1'h1, 5'h04, 10'h004, 10'h00A, 10'h003, 10'h007, 10'h000, 2'h0);
    txq = {mk(1'h0, 2'h0, 1'h0, 16'h00FF), mk(1'h0, 2'h0, 1'h1, 16'hC3C3)};
    fork send(); capture(); join
    for (int i = 0; i < 4 * ln; i++) begin
      c = i % (2 * ln);
      a = c < ln;
      cmp_pin(cs_c[i], a ? ep(c, u, d, 1'h1) : 2'h0);
      cmp_pin(wr_c[i], a ? ep(c, 0, 2 * ln, 1'h1) : 2'h0);
      cmp_pin(rd_c[i], 2'h0);
      if (a) cmp_word(do_c[i], i < ln ? 16'h00FF : 16'hC3C3);
    end
    $display("test single_pol done");
  endtask : single_pol_test

  task automatic read_check(logic m6, int w, logic [15:0] r);
    int ln, u, d, s, base;
    base = cdiv(75, 10);
    ln = base * (w + 1);
    u = cdiv(14, 10);
    d = cdiv(130, 10) + 2 * base * w;
    s = cdiv(55, 10) + base * w;
    setup(1'h1, m6, 4'h0, 1'h0, 5'h04, 10'h00A, 10'h04B, 10'h007, 10'h041, 10'h037, w[1:0]);
    resp <= r;
    txq = {mk(1'h1, 2'h2, 1'h1, 16'h0000)};
    fork send(); capture(); join
    for (int i = 0; i < ln; i++) begin
      cmp_pin(cs_c[i], ep(i, 0, 2 * ln, 1'h0));
      cmp_pin(m6 ? wr_c[i] : rd_c[i], ep(i, u, d, 1'h0));
      cmp_pin(m6 ? rd_c[i] : wr_c[i], m6 ? ep(i, 0, 2 * ln, 1'h0) : 2'h3);
      cmp_pin({1'h0, oe_c[i]}, 2'h1);
      cmp_pin({1'h0, rs_c[i]}, 2'h0);
      cmp_pin(ds_c[i], 2'h2);
    end
    cmp_pin(cs_c[ln], 2'h3);
    cmp_pin({rv_c[s + 2], rv_c[s + 3]}, 2'h1);
    cmp_word(rx_c[s + 3], r);
  endtask : read_check

  task automatic read_sys80_test();
    read_check(1'h0, 0, 16'hA5C3);
    $display("test read_sys80 done");
  endtask : read_sys80_test

  task automatic read_wait_68k_test();
    read_check(1'h1, 1, 16'h3C5A);
    $display("test read_wait_68k done");
  endtask : read_wait_68k_test

  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    reset = 1'h1;
    req_valid = 1'h0;
    req_data = '0;
    {clkp, per, up, dn, smp} = {10'h00A, 10'h014, 10'h000, 10'h00A, 10'h00A};
    {pol, m68k, type2, single, pause, rwait, resp} = {4'h0, 3'h0, 5'h04, 2'h0, 16'h0000};
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
    reset_test();
    write_burst_test();
    single_pol_test();
    read_sys80_test();
    read_wait_68k_test();
    complete_run();
  end
endmodule : adpt_top_test

// >>> hw/adpt_pkg.sv
package adpt_pkg;

  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CNT_W        = 14;
  localparam int unsigned CFG_W_MAX    = 12;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned PAUSE_W      = 5;
  localparam logic [4:0]  PAUSE_MIN    = 5'h04;
  localparam logic [4:0]  PAUSE_MAX    = 5'h13;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [3:0]  POL_RESET    = 4'h0;
  localparam int unsigned POL_CS_BIT   = 0;
  localparam int unsigned POL_RD_BIT   = 1;
  localparam int unsigned POL_WR_BIT   = 2;
  localparam int unsigned POL_RS_BIT   = 3;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ADPT_IDLE,
    ADPT_ACCESS,
    ADPT_GAP,
    ADPT_PAUSE
  } adpt_state_e;

  typedef struct packed {
    logic              is_read;
    logic              rs;
    logic [1:0]        disp;
    logic              last;
    logic [DATA_W-1:0] data;
  } adpt_req_s;

  typedef struct packed {
    adpt_state_e       st;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  len;
    logic [CNT_W-1:0]  up;
    logic [CNT_W-1:0]  dn;
    logic [CNT_W-1:0]  smp;
    adpt_req_s         cur;
    logic [DATA_W-1:0] sy1;
    logic [DATA_W-1:0] sy2;
    logic [1:0]        pipe;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic [1:0]        cs_a;
    logic [1:0]        rd_a;
    logic [1:0]        wr_a;
    logic              rs_a;
    logic [DATA_W-1:0] dout;
    logic              oe_n;
    logic [1:0]        disp;
  } adpt_st_s;

endpackage : adpt_pkg

// >>> hw/adpt_top.sv
// Contract
// - read period is ceil of period over clock
// - write period is ceil of period over clock
// - read release at half-cycle ceil point
// - read assert at half-cycle ceil point
// - write release at half-cycle ceil point
// - write assert at half-cycle ceil point
// - read strobe active only from up to down
// - write strobe active only from up to down
// - read controls stable across whole period
// - write controls stable across whole period
// - write data held through whole period
// - each control pin has programmable polarity
// - timing values come from software settings
// - back-to-back accesses repeat at exact period
// - type 1 and type 2, system 80/68k
// - single mode: one idle period after access
// - pause of 4 to 19 cycles between bursts
// - n read wait states stretch read to n+1 periods
`timescale 1ns/10ps

module adpt_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } adpt_fptr_s;

  adpt_fptr_s q_r;
  adpt_fptr_s q_nxt;
  logic [W-1:0] mem [DEPTH];

  assign s_ready = !((q_r.wp[AW] != q_r.rp[AW]) && (q_r.wp[AW-1:0] == q_r.rp[AW-1:0]));
  assign m_valid = (q_r.wp != q_r.rp);
  assign m_data  = mem[q_r.rp[AW-1:0]];

  always_comb begin
    q_nxt = q_r;
    if (s_valid && s_ready) begin
      q_nxt.wp = q_r.wp + 1'b1;
    end
    if (m_valid && m_ready) begin
      q_nxt.rp = q_r.rp + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
    if (s_valid && s_ready) begin
      mem[q_r.wp[AW-1:0]] <= s_data;
    end
  end
endmodule : adpt_fifo

module adpt_top #(
  parameter int unsigned CFG_W = 10
) (
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic                           req_valid,
  output logic                                req_ready,
  input  wire adpt_pkg::adpt_req_s            req_data,
  output logic                                rdata_valid,
  output logic [adpt_pkg::DATA_W-1:0]         rdata,
  input  wire logic [CFG_W-1:0]               read_period_setting,
  input  wire logic [CFG_W-1:0]               write_period_setting,
  input  wire logic [CFG_W-1:0]               fast_clock_period_setting,
  input  wire logic [CFG_W-1:0]               read_assert_setting,
  input  wire logic [CFG_W-1:0]               read_release_setting,
  input  wire logic [CFG_W-1:0]               write_assert_setting,
  input  wire logic [CFG_W-1:0]               write_release_setting,
  input  wire logic [CFG_W-1:0]               read_sample_setting,
  input  wire logic [3:0]                     display_signal_polarity_reg,
  input  wire logic                           mode_68k,
  input  wire logic                           type2_sel,
  input  wire logic                           single_access,
  input  wire logic [adpt_pkg::PAUSE_W-1:0]   pause_cycles,
  input  wire logic [1:0]                     read_wait_states,
  output logic                                busy,
  output logic [1:0]                          cs_pin,
  output logic [1:0]                          rd_pin,
  output logic [1:0]                          wr_pin,
  output logic                                rs_pin,
  output logic [1:0]                          disp_sel,
  output logic [adpt_pkg::DATA_W-1:0]         data_o,
  output logic                                data_oe_n,
  input  wire logic [adpt_pkg::DATA_W-1:0]    data_i
);
  import adpt_pkg::*;

  if (CFG_W < 2 || CFG_W > CFG_W_MAX) begin : g_chk
    $error("setting width out of range");
  end

  adpt_st_s  q_r;
  adpt_st_s  q_nxt;
  adpt_req_s f_data;
  logic      f_valid;
  logic      f_pop;

  adpt_fifo #(
    .W     ($bits(adpt_req_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .reset   (reset),
    .s_valid (req_valid),
    .s_ready (req_ready),
    .s_data  (req_data),
    .m_valid (f_valid),
    .m_ready (f_pop),
    .m_data  (f_data)
  );

  function automatic logic [CNT_W-1:0] cdiv(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    logic [CNT_W-1:0] bb;
    bb = (b == '0) ? CNT_W'(1) : b;
    return CNT_W'((a + bb - CNT_W'(1)) / bb);
  endfunction : cdiv

  logic [CNT_W-1:0] per_c;
  logic [CNT_W-1:0] base_rd;
  logic [CNT_W-1:0] base_wr;
  logic [CNT_W-1:0] pause_len;
  logic [2:0]       wait_n;

  always_comb begin
    per_c   = CNT_W'(fast_clock_period_setting);
    base_rd = cdiv(CNT_W'(read_period_setting), per_c);
    base_wr = cdiv(CNT_W'(write_period_setting), per_c);
    if (base_rd == '0) begin
      base_rd = CNT_W'(1);
    end
    if (base_wr == '0) begin
      base_wr = CNT_W'(1);
    end
    wait_n    = 3'(read_wait_states) + 3'h1;
    pause_len = CNT_W'(pause_cycles);
    if (pause_cycles < PAUSE_MIN) begin
      pause_len = CNT_W'(PAUSE_MIN);
    end else if (pause_cycles > PAUSE_MAX) begin
      pause_len = CNT_W'(PAUSE_MAX);
    end
  end

  logic             last_cyc;
  logic             start;
  logic             acc;
  logic             rd_acc;
  logic [CNT_W-1:0] base;
  logic [CNT_W-1:0] xtra;
  logic [CNT_W:0]   slot [2];
  logic [1:0]       stb;

  always_comb begin
    q_nxt        = q_r;
    q_nxt.sy1    = data_i;
    q_nxt.sy2    = q_r.sy1;
    q_nxt.pipe   = {q_r.pipe[0], 1'b0};
    q_nxt.rvalid = 1'b0;
    f_pop        = 1'b0;
    start        = 1'b0;
    base         = '0;
    xtra         = '0;
    last_cyc     = (q_r.cnt == q_r.len - CNT_W'(1));
    if (q_r.pipe[1]) begin
      q_nxt.rdata  = q_r.sy2;
      q_nxt.rvalid = 1'b1;
    end
    case (q_r.st)
      ADPT_IDLE: begin
        start = f_valid;
      end
      ADPT_ACCESS: begin
        if (q_r.cur.is_read && q_r.cnt == q_r.smp) begin
          q_nxt.pipe[0] = 1'b1;
        end
        if (!last_cyc) begin
          q_nxt.cnt = q_r.cnt + CNT_W'(1);
        end else if (single_access) begin
          q_nxt.st  = ADPT_GAP;
          q_nxt.cnt = '0;
        end else if (q_r.cur.last || (f_valid && f_data.disp != q_r.cur.disp)) begin
          q_nxt.st  = ADPT_PAUSE;
          q_nxt.cnt = '0;
        end else if (f_valid) begin
          start = 1'b1;
        end else begin
          q_nxt.st = ADPT_IDLE;
        end
      end
      ADPT_GAP: begin
        q_nxt.cnt = q_r.cnt + CNT_W'(1);
        if (last_cyc) begin
          q_nxt.cnt = '0;
          if (q_r.cur.last || (f_valid && f_data.disp != q_r.cur.disp)) begin
            q_nxt.st = ADPT_PAUSE;
          end else begin
            q_nxt.st = ADPT_IDLE;
            start    = f_valid;
          end
        end
      end
      ADPT_PAUSE: begin
        q_nxt.cnt = q_r.cnt + CNT_W'(1);
        if (q_r.cnt >= pause_len - CNT_W'(1)) begin
          q_nxt.st = ADPT_IDLE;
          start    = f_valid;
        end
      end
      default: begin
        q_nxt.st = ADPT_IDLE;
      end
    endcase
    if (start) begin
      f_pop     = 1'b1;
      q_nxt.st  = ADPT_ACCESS;
      q_nxt.cnt = '0;
      q_nxt.cur = f_data;
      if (f_data.is_read) begin
        base      = base_rd;
        xtra      = CNT_W'(base_rd * (wait_n - 3'h1));
        q_nxt.len = CNT_W'(base_rd * wait_n);
        q_nxt.up  = cdiv(CNT_W'({read_assert_setting, 1'b0}), per_c);
        q_nxt.dn  = cdiv(CNT_W'({read_release_setting, 1'b0}), per_c);
        q_nxt.smp = cdiv(CNT_W'(read_sample_setting), per_c) + xtra;
        q_nxt.dn  = q_nxt.dn + CNT_W'({xtra, 1'b0});
      end else begin
        base      = base_wr;
        q_nxt.len = base_wr;
        q_nxt.up  = cdiv(CNT_W'({write_assert_setting, 1'b0}), per_c);
        q_nxt.dn  = cdiv(CNT_W'({write_release_setting, 1'b0}), per_c);
        q_nxt.smp = '0;
      end
      if (q_nxt.smp >= q_nxt.len) begin
        q_nxt.smp = q_nxt.len - CNT_W'(1);
      end
      if (base == '0) begin
        q_nxt.len = CNT_W'(1);
      end
    end
    acc     = (q_nxt.st == ADPT_ACCESS);
    rd_acc  = acc && q_nxt.cur.is_read;
    slot[0] = {q_nxt.cnt, 1'b0};
    slot[1] = {q_nxt.cnt, 1'b1};
    for (int i = 0; i < 2; i++) begin
      stb[i] = acc && ({1'b0, q_nxt.up} <= slot[i]) && (slot[i] < {1'b0, q_nxt.dn});
    end
    if (!type2_sel) begin
      q_nxt.cs_a = stb;
      q_nxt.rd_a = {2{rd_acc}};
      q_nxt.wr_a = mode_68k ? {2{acc}} : {2{acc && !q_nxt.cur.is_read}};
    end else begin
      q_nxt.cs_a = {2{acc}};
      q_nxt.rd_a = mode_68k ? {2{rd_acc}} : (stb & {2{rd_acc}});
      q_nxt.wr_a = mode_68k ? stb : (stb & {2{acc && !q_nxt.cur.is_read}});
    end
    q_nxt.rs_a = acc && q_nxt.cur.rs;
    q_nxt.disp = acc ? q_nxt.cur.disp : q_r.disp;
    q_nxt.oe_n = !(acc && !q_nxt.cur.is_read);
    if (acc && !q_nxt.cur.is_read) begin
      q_nxt.dout = q_nxt.cur.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_r      <= '0;
      q_r.st   <= ADPT_IDLE;
      q_r.oe_n <= 1'b1;
      q_r.dout <= DATA_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // pins: active level xnor polarity, zero means active low
  assign cs_pin      = ~(q_r.cs_a ^ {2{display_signal_polarity_reg[POL_CS_BIT]}});
  assign rd_pin      = ~(q_r.rd_a ^ {2{display_signal_polarity_reg[POL_RD_BIT]}});
  assign wr_pin      = ~(q_r.wr_a ^ {2{display_signal_polarity_reg[POL_WR_BIT]}});
  assign rs_pin      = ~(q_r.rs_a ^ display_signal_polarity_reg[POL_RS_BIT]);
  assign disp_sel    = q_r.disp;
  assign data_o      = q_r.dout;
  assign data_oe_n   = q_r.oe_n;
  assign rdata       = q_r.rdata;
  assign rdata_valid = q_r.rvalid;
  assign busy        = (q_r.st != ADPT_IDLE) || f_valid;

  // checks
  logic [CNT_W-1:0] ref_rd_len;
  assign ref_rd_len = CNT_W'(base_rd * wait_n);

  rd_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && q_r.cnt == '0 && q_r.cur.is_read) |-> q_r.len == ref_rd_len)
    else $error("read period length wrong");

  wr_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && q_r.cnt == '0 && !q_r.cur.is_read) |-> q_r.len == base_wr)
    else $error("write period length wrong");

  strobe_win_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && !q_r.cur.is_read && type2_sel && !mode_68k) |->
      q_r.wr_a[0] == (({1'b0, q_r.up} <= {q_r.cnt, 1'b0}) && ({q_r.cnt, 1'b0} < {1'b0, q_r.dn})))
    else $error("write strobe outside window");

  back_back_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && last_cyc && start) |=> (q_r.st == ADPT_ACCESS && q_r.cnt == '0))
    else $error("back to back access delayed");

  single_gap_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && last_cyc && single_access) |=> (q_r.cs_a == 2'b00 && q_r.rd_a == 2'b00))
    else $error("controls active in single gap");

  burst_pause_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && last_cyc && !single_access && q_r.cur.last) |=>
      (q_r.st == ADPT_PAUSE && q_r.cs_a == 2'b00) [*4])
    else $error("pause shorter than four cycles");

  wdata_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && !q_r.cur.is_read && q_r.cnt != '0) |-> ($stable(data_o) && !data_oe_n))
    else $error("write data moved inside period");

  ctrl_stable_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && q_r.cnt != '0) |-> ($stable(rs_pin) && $stable(disp_sel)))
    else $error("controls moved inside period");

  sample_pt_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && q_r.cur.is_read && q_r.cnt == q_r.smp) |-> ##3 rdata_valid)
    else $error("read sample not returned");

  idle_pol_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_IDLE) |-> (cs_pin == {2{~display_signal_polarity_reg[POL_CS_BIT]}}))
    else $error("idle chip select level wrong");

  type2_cs_a: assert property (@(posedge sys_clk) disable iff (reset)
    (q_r.st == ADPT_ACCESS && type2_sel) |-> q_r.cs_a == 2'b11)
    else $error("type 2 chip select dropped");
endmodule : adpt_top
